// ---- asc_pkg.sv ----
// constants, field layouts and lookups for the setup configuration bank
// assumes a single 10 MHz clock and a same-clock register master
// Summary of operation
// - eight 16-bit setup registers, 0x19 to 0x20
// - channel selects which setup it applies
// - bits 15:13 set source one magnitude
// - bits 12:10 set source zero magnitude
// - bits 9:8 select burnout current
// - bit 7 enables positive reference buffer
// - bit 6 enables negative reference buffer
// - bits 5:4 select reference source
// - bits 3:1 set gain two to code
// - bit 0 bypasses amplifier, gain one
// - channel bits 3:0 route source zero
// - source one route decodes as input number
// - channel bits 7:4 hold source one route
`default_nettype none
package asc_pkg;

	localparam int ASC_NUM_SETUPS = 8;
	localparam int ASC_NUM_CHANS = 16;
	localparam int ASC_NUM_INPUTS = 16;

	localparam logic [7:0] ASC_SETUP_BASE = 8'h19;
	localparam logic [7:0] ASC_SETUP_LAST = 8'h20;
	localparam logic [7:0] ASC_CHAN_BASE = 8'h30;
	localparam logic [7:0] ASC_CHAN_LAST = 8'h3F;

	localparam logic [15:0] ASC_SETUP_RST = 16'h0000;
	localparam logic [15:0] ASC_CHAN_RST = 16'h0000;
	// channel bits that hold state; the rest read as zero
	localparam logic [15:0] ASC_CHAN_MASK = 16'h07FF;
	localparam logic [15:0] ASC_RD_IDLE = 16'h0000;

	localparam logic [2:0] ASC_MAG_OFF = 3'h0;
	localparam logic [7:0] ASC_GAIN_UNITY = 8'h01;

	typedef enum logic [1:0] {
		ASC_REF_EXT1 = 2'h0,
		ASC_REF_EXT2 = 2'h1,
		ASC_REF_INTERNAL = 2'h2,
		ASC_REF_SUPPLY = 2'h3
	} asc_ref_t;

	typedef struct packed {
		logic [2:0] excite_src1_magnitude;
		logic [2:0] excite_src0_magnitude;
		logic [1:0] burnout_code;
		logic ref_pos_buffer_en;
		logic ref_neg_buffer_en;
		asc_ref_t ref_source;
		logic [2:0] amp_gain_code;
		logic amp_bypass;
	} asc_setup_t;

	typedef struct packed {
		logic [4:0] rsvd;
		logic [2:0] setup_sel;
		logic [3:0] excite_src1_route;
		logic [3:0] excite_src0_route;
	} asc_chan_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} asc_bus_req_t;

	// currents in units of 100 nA
	typedef struct packed {
		logic [2:0] setup_sel;
		logic [10:0] src0_current;
		logic [10:0] src1_current;
		logic [15:0] src0_pin_en;
		logic [15:0] src1_pin_en;
		logic [10:0] burnout_current;
		logic ref_pos_buffer_en;
		logic ref_neg_buffer_en;
		asc_ref_t ref_source;
		logic [7:0] amp_gain;
		logic amp_bypass;
	} asc_drive_t;

	function automatic logic [10:0] asc_mag_current(input logic [2:0] c);
		unique case (c)
			3'h0: asc_mag_current = 11'h000;
			3'h1: asc_mag_current = 11'h064;
			3'h2: asc_mag_current = 11'h0C8;
			3'h3: asc_mag_current = 11'h1F4;
			3'h4: asc_mag_current = 11'h3E8;
			3'h5: asc_mag_current = 11'h5DC;
			3'h6: asc_mag_current = 11'h7D0;
			3'h7: asc_mag_current = 11'h001;
		endcase
	endfunction : asc_mag_current

	function automatic logic [10:0] asc_burnout_current(input logic [1:0] c);
		unique case (c)
			2'h0: asc_burnout_current = 11'h000;
			2'h1: asc_burnout_current = 11'h005;
			2'h2: asc_burnout_current = 11'h014;
			2'h3: asc_burnout_current = 11'h028;
		endcase
	endfunction : asc_burnout_current

endpackage : asc_pkg
`default_nettype wire

// ---- asc_setup_bank.sv ----
// setup configuration bank: eight setups, sixteen channel routing words
// assumes the register master and channel sequencer share sys_clk_in
`timescale 1ns/10ps
`default_nettype none
module asc_setup_bank import asc_pkg::*; (
	input wire logic sys_clk_in, // 10 MHz clock
	input wire logic rst_in, // async reset, active high
	input wire asc_bus_req_t bus_req_in, // register request
	input wire logic [3:0] active_chan_in, // channel being converted
	output logic [15:0] rd_data_out, // read data, cycle after read
	output asc_drive_t drive_out // decoded front-end controls
);

////////////////////////////////////////////////////////////////////////

	asc_setup_t setup_reg [ASC_NUM_SETUPS];
	asc_setup_t setup_next [ASC_NUM_SETUPS];
	asc_chan_t chan_reg [ASC_NUM_CHANS];
	asc_chan_t chan_next [ASC_NUM_CHANS];
	logic [15:0] rd_data_reg;
	logic [15:0] rd_data_next;
	asc_drive_t drive_reg;
	asc_drive_t drive_next;

	logic setup_hit;
	logic chan_hit;
	logic [2:0] setup_idx;
	logic [3:0] chan_idx;
	logic [7:0] setup_off;
	logic [7:0] chan_off;

	assign setup_off = bus_req_in.addr - ASC_SETUP_BASE;
	assign chan_off = bus_req_in.addr - ASC_CHAN_BASE;
	assign setup_hit = (bus_req_in.addr >= ASC_SETUP_BASE) &&
		(bus_req_in.addr <= ASC_SETUP_LAST);
	assign chan_hit = (bus_req_in.addr >= ASC_CHAN_BASE) &&
		(bus_req_in.addr <= ASC_CHAN_LAST);
	assign setup_idx = setup_off[2:0];
	assign chan_idx = chan_off[3:0];

////////////////////////////////////////////////////////////////////////
// register file

	always_comb begin
		for (int i = 0; i < ASC_NUM_SETUPS; i++) begin
			setup_next[i] = setup_reg[i];
		end
		for (int i = 0; i < ASC_NUM_CHANS; i++) begin
			chan_next[i] = chan_reg[i];
		end
		// only the addressed word changes
		if (bus_req_in.wr && setup_hit) begin
			setup_next[setup_idx] = bus_req_in.wdata;
		end
		if (bus_req_in.wr && chan_hit) begin
			chan_next[chan_idx] = bus_req_in.wdata & ASC_CHAN_MASK;
		end
		rd_data_next = ASC_RD_IDLE;
		if (bus_req_in.rd && setup_hit) begin
			rd_data_next = setup_reg[setup_idx];
		end else if (bus_req_in.rd && chan_hit) begin
			rd_data_next = chan_reg[chan_idx];
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < ASC_NUM_SETUPS; i++) begin
				setup_reg[i] <= ASC_SETUP_RST;
			end
			for (int i = 0; i < ASC_NUM_CHANS; i++) begin
				chan_reg[i] <= ASC_CHAN_RST;
			end
			rd_data_reg <= ASC_RD_IDLE;
		end else begin
			for (int i = 0; i < ASC_NUM_SETUPS; i++) begin
				setup_reg[i] <= setup_next[i];
			end
			for (int i = 0; i < ASC_NUM_CHANS; i++) begin
				chan_reg[i] <= chan_next[i];
			end
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_data_out = rd_data_reg;

////////////////////////////////////////////////////////////////////////
// front-end decode for the active channel

	asc_chan_t cur_chan;
	asc_setup_t cur_setup;

	assign cur_chan = chan_reg[active_chan_in];
	// setups are shared; the channel only names one
	assign cur_setup = setup_reg[cur_chan.setup_sel];

	always_comb begin
		drive_next = '0;
		drive_next.setup_sel = cur_chan.setup_sel;
		drive_next.src1_current =
			asc_mag_current(cur_setup.excite_src1_magnitude);
		drive_next.src0_current =
			asc_mag_current(cur_setup.excite_src0_magnitude);
		// a source that is off drives no pin at all
		if (cur_setup.excite_src0_magnitude != ASC_MAG_OFF) begin
			drive_next.src0_pin_en[cur_chan.excite_src0_route] = 1'b1;
		end
		if (cur_setup.excite_src1_magnitude != ASC_MAG_OFF) begin
			drive_next.src1_pin_en[cur_chan.excite_src1_route] = 1'b1;
		end
		drive_next.burnout_current =
			asc_burnout_current(cur_setup.burnout_code);
		drive_next.ref_pos_buffer_en = cur_setup.ref_pos_buffer_en;
		drive_next.ref_neg_buffer_en = cur_setup.ref_neg_buffer_en;
		drive_next.ref_source = cur_setup.ref_source;
		drive_next.amp_bypass = cur_setup.amp_bypass;
		if (cur_setup.amp_bypass) begin
			drive_next.amp_gain = ASC_GAIN_UNITY;
		end else begin
			drive_next.amp_gain =
				ASC_GAIN_UNITY << cur_setup.amp_gain_code;
		end
	end

	// registered so the analog controls never glitch on a mux change
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			drive_reg <= '0;
		end else begin
			drive_reg <= drive_next;
		end
	end

	assign drive_out = drive_reg;

////////////////////////////////////////////////////////////////////////
// checks

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	chk_setup_readback: assert property (
		bus_req_in.wr && setup_hit ##1
		bus_req_in.rd && !bus_req_in.wr &&
		bus_req_in.addr == $past(bus_req_in.addr)
		|=> rd_data_out == $past(bus_req_in.wdata, 2))
		else $error("setup read does not return last write");

	chk_rd_unmapped: assert property (
		bus_req_in.rd && !setup_hit && !chan_hit
		|=> rd_data_out == ASC_RD_IDLE)
		else $error("unmapped read not zero");

	chk_rd_idle: assert property (
		!bus_req_in.rd |=> rd_data_out == ASC_RD_IDLE)
		else $error("read data outside its cycle");

	chk_chan_readback: assert property (
		bus_req_in.wr && chan_hit ##1
		bus_req_in.rd && !bus_req_in.wr &&
		bus_req_in.addr == $past(bus_req_in.addr)
		|=> rd_data_out == ($past(bus_req_in.wdata, 2) & ASC_CHAN_MASK))
		else $error("channel read does not return last write");

	for (genvar g = 0; g < ASC_NUM_SETUPS; g++) begin : g_iso
		chk_write_isolated: assert property (
			!(bus_req_in.wr && setup_hit && setup_idx == g)
			|=> $stable(setup_reg[g]))
			else $error("setup word changed without its write");
	end

	chk_bypass_gain: assert property (
		drive_out.amp_bypass |-> drive_out.amp_gain == ASC_GAIN_UNITY)
		else $error("bypass gain not one");

	// drive_out still holds its reset zero on the first edge after release
	chk_gain_power: assert property (
		!$past(rst_in) && !$past(cur_setup.amp_bypass) |->
		drive_out.amp_gain ==
		(ASC_GAIN_UNITY << $past(cur_setup.amp_gain_code)))
		else $error("gain not two to the code");

	chk_src0_route: assert property (
		$past(cur_setup.excite_src0_magnitude) != ASC_MAG_OFF |->
		drive_out.src0_pin_en ==
		(16'h0001 << $past(cur_chan.excite_src0_route)))
		else $error("source zero on wrong input");

	chk_src1_route: assert property (
		$past(cur_setup.excite_src1_magnitude) != ASC_MAG_OFF |->
		drive_out.src1_pin_en ==
		(16'h0001 << $past(cur_chan.excite_src1_route)))
		else $error("source one on wrong input");

	chk_src_off: assert property (
		$past(cur_setup.excite_src1_magnitude) == ASC_MAG_OFF |->
		drive_out.src1_pin_en == 16'h0000 && drive_out.src1_current == 11'h000)
		else $error("source one drives while off");

	chk_src0_nano: assert property (
		$past(cur_setup.excite_src0_magnitude) == 3'h7 |->
		drive_out.src0_current == 11'h001)
		else $error("source zero code seven not 100 nA");

	chk_ref_fields: assert property (
		drive_out.ref_pos_buffer_en == $past(cur_setup.ref_pos_buffer_en) &&
		drive_out.ref_neg_buffer_en == $past(cur_setup.ref_neg_buffer_en) &&
		drive_out.ref_source == $past(cur_setup.ref_source))
		else $error("reference controls do not follow setup");

	chk_burnout_max: assert property (
		$past(cur_setup.burnout_code) == 2'h3 |->
		drive_out.burnout_current == 11'h028)
		else $error("burnout code three not 4 uA");

	chk_setup_follow: assert property (
		drive_out.setup_sel == $past(cur_chan.setup_sel))
		else $error("setup index does not follow channel");

	cov_shared_setup: cover property (
		chan_reg[0].setup_sel == chan_reg[1].setup_sel &&
		setup_reg[chan_reg[0].setup_sel] != ASC_SETUP_RST);

	cov_bypass: cover property (
		drive_out.amp_bypass && $past(cur_setup.amp_gain_code) == 3'h7);

	cov_route_top: cover property (drive_out.src0_pin_en[15]);

	cov_readback: cover property (
		bus_req_in.wr && setup_hit ##1 bus_req_in.rd && setup_hit);

endmodule : asc_setup_bank
`default_nettype wire

// ---- asc_tb.sv ----
// self-checking bench for the setup configuration bank
// assumes asc_pkg and asc_setup_bank are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb import asc_pkg::*;;
	logic sys_clk_in;
	logic rst_in;
	asc_bus_req_t bus_req;
	logic [3:0] active_chan;
	logic [15:0] rd_data;
	asc_drive_t drv;
	int error_cnt;
	int cmp_count;
	// currents in 100 nA units
	localparam logic [10:0] MAG [8] = '{11'h000, 11'h064, 11'h0C8, 11'h1F4,
		11'h3E8, 11'h5DC, 11'h7D0, 11'h001};
	localparam logic [10:0] BURN [4] = '{11'h000, 11'h005, 11'h014, 11'h028};
	localparam asc_bus_req_t IDLE = '{addr: 8'h00, wdata: 16'h0000,
		wr: 1'b0, rd: 1'b0};

	asc_setup_bank uut (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.bus_req_in(bus_req),
		.active_chan_in(active_chan),
		.rd_data_out(rd_data),
		.drive_out(drv)
	);

	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// gap cycle after each strobe so no signal is driven twice per step
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk_in);
		bus_req <= IDLE;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk_in);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk_in);
		bus_req <= IDLE;
		#1 chk("rd_data", e, rd_data);
		@(posedge sys_clk_in);
		#1 chk("rd_data idle", 16'h0000, rd_data);
	endtask : rd

	// write then read of the same word with no gap between strobes
	task automatic wr_rd(input logic [7:0] a, input logic [15:0] d,
		input logic [15:0] e);
		@(posedge sys_clk_in);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk_in);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk_in);
		bus_req <= IDLE;
		#1 chk("rd_data b2b", e, rd_data);
	endtask : wr_rd

	task automatic check_drive(input int i, input int j, input logic [3:0] c);
		logic [15:0] gain_exp;
		logic [15:0] pin0_exp;
		logic [15:0] pin1_exp;
		gain_exp = (j != 0) ? 16'h0001 : 16'(1 << i);
		pin0_exp = (i != 7) ? 16'h0001 << c : 16'h0000;
		pin1_exp = (i != 0) ? 16'h0001 << ~c : 16'h0000;
		chk("setup_sel", 16'(i), 16'(drv.setup_sel));
		chk("src1_current", 16'(MAG[i]), 16'(drv.src1_current));
		chk("src0_current", 16'(MAG[7 - i]), 16'(drv.src0_current));
		chk("burnout", 16'(BURN[i % 4]), 16'(drv.burnout_current));
		chk("ref_pos_buf", 16'(i % 2), 16'(drv.ref_pos_buffer_en));
		chk("ref_neg_buf", 16'((i / 2) % 2), 16'(drv.ref_neg_buffer_en));
		chk("ref_source", 16'((i + j) % 4), 16'(drv.ref_source));
		chk("amp_gain", gain_exp, 16'(drv.amp_gain));
		chk("amp_bypass", 16'(j), 16'(drv.amp_bypass));
		chk("src0_pin", pin0_exp, drv.src0_pin_en);
		chk("src1_pin", pin1_exp, drv.src1_pin_en);
	endtask : check_drive

	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		error_cnt++;
		stop_test();
	end

	initial begin
		logic [3:0] c;
		rst_in = 1'b1;
		bus_req = IDLE;
		active_chan = 4'h0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (5) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		for (int k = 0; k < 8; k++) rd(8'h19 + 8'(k), 16'h0000);
		rd(8'h30, 16'h0000);
		$display("test reset values done");
		for (int k = 0; k < 8; k++) wr(8'h19 + 8'(k), 16'h5A30 + 16'(k));
		wr(8'h1C, 16'hFFFF);
		for (int k = 0; k < 8; k++) begin
			rd(8'h19 + 8'(k), (k == 3) ? 16'hFFFF : 16'h5A30 + 16'(k));
		end
		wr(8'h21, 16'hBEEF);
		wr(8'h18, 16'hBEEF);
		rd(8'h21, 16'h0000);
		rd(8'h18, 16'h0000);
		rd(8'h20, 16'h5A37);
		wr(8'h3F, 16'hFFFF);
		rd(8'h3F, 16'h07FF);
		wr_rd(8'h1A, 16'hC3A5, 16'hC3A5);
		wr_rd(8'h35, 16'hFFFF, 16'h07FF);
		$display("test register access done");
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 2; j++) begin
				c = 4'(i * 2 + j);
				// gain code still set while bypassed, so bypass must win
				wr(8'h19 + 8'(i), {3'(i), 3'(7 - i), 2'(i), 1'(i % 2),
					1'((i / 2) % 2), 2'((i + j) % 4), 3'(i), 1'(j)});
				wr(8'h30 + 8'(c), {5'h00, 3'(i), ~c, c});
				active_chan <= c;
				repeat (2) @(posedge sys_clk_in);
				#1 check_drive(i, j, c);
			end
		end
		$display("test setup decode done");
		stop_test();
	end
endmodule : tb
`default_nettype wire
